/* File: rtl/boundary_scan_tap.sv */
// Boundary-scan test access port: controller, instruction register, bypass,
// identification and boundary register, with a core-side capture stream.
// Assumes tck comes from an external tester; clk is the core clock; trst is
// asynchronous and active high here (pin inversion is done outside).
// Two domains meet here: the controller, chain and pin registers run on tck,
// the capture stream on clk. Only a toggle and a held word cross between them,
// and the programmed level crosses the other way on a two-flop synchroniser.
`timescale 1ns/1ns
module boundary_scan_tap
	import tap_pkg::*;
#(
	parameter int N_IO   = 4,
	parameter int FIFO_D = 4
) (
	// Core clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Test port, tck domain
	input  wire logic              tck,
	input  wire logic              trst,
	input  wire logic              tms,
	input  wire logic              tdi,
	output logic                   tdo,
	output logic                   tdo_oe,
	// Device state
	input  wire logic              programmed,
	// Core side of the I/O buffers
	input  wire logic [N_IO-1:0]   core_out,
	input  wire logic [N_IO-1:0]   core_oe,
	output logic [N_IO-1:0]        core_in,
	// Pad side of the I/O buffers
	input  wire logic [N_IO-1:0]   pad_in,
	output logic [N_IO-1:0]        pad_out,
	output logic [N_IO-1:0]        pad_oe,
	// Captured boundary words towards the core, and the pin mux select
	output logic                   cap_valid,
	input  wire logic              cap_ready,
	output logic [3*N_IO-1:0]      cap_data,
	output logic                   test_mode
);
	localparam int BSR_W = CELLS_PER_IO * N_IO;

	tap_state_t        st_r;
	tap_state_t        st_nxt;
	logic [IR_W-1:0]   ir_sh_r;
	logic [IR_W-1:0]   ir_r;
	logic              byp_r;
	logic [ID_W-1:0]   id_r;
	logic [BSR_W-1:0]  bsr_sh_r;
	logic [BSR_W-1:0]  bsr_upd_r;
	logic [BSR_W-1:0]  par_in;
	logic              sel_bsr;
	logic              sel_id;
	logic              drive_pins;
	logic              prog_s1_r;
	logic              prog_s2_r;
	logic              tdo_nxt;
	logic              cap_tgl_r;
	logic [BSR_W-1:0]  cap_word_r;

	// power-up and trst both reset the controller asynchronously.
	// Merging them costs a gate in the reset path but saves a second reset
	// tree; both sources are clean levels from outside.
	logic tap_rst;
	assign tap_rst = reset | trst;

	// sixteen-state graph
	// Every state names both successors, so no state can be left stranded
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_RESET:  st_nxt = tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   st_nxt = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: st_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
			// tms high walks here within five edges
			ST_SEL_IR: st_nxt = tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: st_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	// state advances on tck rising edge
	// The tester launches tms off the falling edge, so it is already in this domain
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Programmed flag crosses into the tck domain on two flops
	// The level moves once in the life of the device, so no handshake is needed
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			prog_s1_r <= 1'b0;
			prog_s2_r <= 1'b0;
		end else begin
			prog_s1_r <= programmed;
			prog_s2_r <= prog_s1_r;
		end
	end

	// instruction shift, LSB first, capture pattern 01
	// The fixed 01 in the low bits lets a tester prove the chain is unbroken
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			ir_sh_r <= OP_BYPASS;
		end else if (st_r == ST_CAP_IR) begin
			ir_sh_r <= {{(IR_W-2){1'b0}}, IR_CAPTURE_VAL};
		end else if (st_r == ST_SH_IR) begin
			ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
		end
	end

	// active instruction: BYPASS in reset, loaded on falling edge of Update-IR
	// Falling-edge load keeps the decode steady around every rising edge
	always_ff @(negedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			ir_r <= OP_BYPASS;
		end else if (st_r == ST_RESET) begin
			ir_r <= OP_BYPASS;
		end else if (st_r == ST_UPD_IR) begin
			ir_r <= ir_sh_r;
		end
	end

	// one match per known opcode except BYPASS
	// Opcodes outside the table match none of these and leave bypass selected
	logic is_extest;
	logic is_sample;
	logic is_clamp;
	logic is_idcode;
	assign is_extest = (ir_r == OP_EXTEST);
	assign is_sample = (ir_r == OP_SAMPLE);
	assign is_clamp  = (ir_r == OP_CLAMP);
	assign is_idcode = (ir_r == OP_IDCODE);
	// EXTEST needs programming; before that the chain shifts but pins stay functional
	assign drive_pins = (is_extest && prog_s2_r) || is_clamp;
	// anything not boundary or id falls to bypass
	assign sel_bsr = is_extest || is_sample;
	assign sel_id  = is_idcode;

	// bypass bit cleared in Capture-DR
	// A known zero first out marks where this device sits in a long chain
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			byp_r <= 1'b0;
		end else if (st_r == ST_CAP_DR) begin
			byp_r <= 1'b0;
		end else if (st_r == ST_SH_DR) begin
			byp_r <= tdi;
		end
	end

	// identification register, four fields
	// Capture reloads the fixed value, so every scan starts from a clean word
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			id_r <= {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
		end else if (st_r == ST_CAP_DR && sel_id) begin
			id_r <= {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
		end else if (st_r == ST_SH_DR && sel_id) begin
			id_r <= {tdi, id_r[ID_W-1:1]};
		end
	end

	// three cells per I/O: pad input, output, output enable
	// Fixed order per I/O: the pad input cell leaves the chain first
	genvar gi;
	generate
		for (gi = 0; gi < N_IO; gi++) begin : g_cell
			assign par_in[3*gi]   = pad_in[gi];
			assign par_in[3*gi+1] = core_out[gi];
			assign par_in[3*gi+2] = core_oe[gi];
		end
	endgenerate

	// one chain, tdi enters the top cell, bit 0 drives tdo
	// Reset clears the chain so an early update cannot drive stale values
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			bsr_sh_r <= '0;
		end else if (st_r == ST_CAP_DR && sel_bsr) begin
			bsr_sh_r <= par_in;
		end else if (st_r == ST_SH_DR && sel_bsr) begin
			bsr_sh_r <= {tdi, bsr_sh_r[BSR_W-1:1]};
		end
	end

	// Update latches change on the falling edge so they settle before the rising edge that loads the pins
	always_ff @(negedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			bsr_upd_r <= '0;
		end else if (st_r == ST_UPD_DR && sel_bsr) begin
			bsr_upd_r <= bsr_sh_r;
		end
	end

	// pin muxing; CLAMP holds preloaded values on the pads
	// The outside mux switches on test_mode; these registers only hold levels,
	// so SAMPLE may preload them without disturbing the functional pins
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			test_mode <= 1'b0;
		end else begin
			test_mode <= drive_pins;
		end
	end
	generate
		for (gi = 0; gi < N_IO; gi++) begin : g_pin
			// Registered outputs follow the update latches on the next tck edge
			always_ff @(posedge tck or posedge tap_rst) begin
				if (tap_rst) begin
					pad_out[gi] <= 1'b0;
					pad_oe[gi]  <= 1'b0;
					core_in[gi] <= 1'b0;
				end else begin
					pad_out[gi] <= bsr_upd_r[3*gi+1];
					pad_oe[gi]  <= bsr_upd_r[3*gi+2];
					core_in[gi] <= bsr_upd_r[3*gi];
				end
			end
		end
	endgenerate

	// output select; tdo changes on the falling edge
	// Falling-edge tdo gives the tester half a tck period of margin at its edge
	always_comb begin
		tdo_nxt = byp_r;
		if (st_r == ST_SH_IR) begin
			tdo_nxt = ir_sh_r[0];
		end else if (sel_bsr) begin
			tdo_nxt = bsr_sh_r[0];
		end else if (sel_id) begin
			tdo_nxt = id_r[0];
		end
	end
	always_ff @(negedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo    <= tdo_nxt;
			tdo_oe <= (st_r == ST_SH_IR) || (st_r == ST_SH_DR);
		end
	end

	// Each boundary-register capture toggles a flag; the word is held until the next capture
	// A toggle, not a pulse, so the slower clk cannot miss a short capture state
	always_ff @(posedge tck or posedge tap_rst) begin
		if (tap_rst) begin
			cap_tgl_r  <= 1'b0;
			cap_word_r <= '0;
		end else if (st_r == ST_CAP_DR && sel_bsr) begin
			cap_tgl_r  <= ~cap_tgl_r;
			cap_word_r <= par_in;
		end
	end

	// Toggle crossing into clk; word is stable for many clk cycles by then
	// Limitation: captures must stand at least four clk periods apart, or the
	// core side may read a word while the next capture rewrites it. Tight
	// Capture-DR loops faster than that are not supported.
	// Only tg_s2_r and tg_s3_r are read; tg_s1_r may be metastable.
	logic             tg_s1_r;
	logic             tg_s2_r;
	logic             tg_s3_r;
	logic             push_r;
	logic [BSR_W-1:0] push_word_r;
	logic             f_ready;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tg_s1_r     <= 1'b0;
			tg_s2_r     <= 1'b0;
			tg_s3_r     <= 1'b0;
			push_r      <= 1'b0;
			push_word_r <= '0;
		end else begin
			tg_s1_r <= cap_tgl_r;
			tg_s2_r <= tg_s1_r;
			tg_s3_r <= tg_s2_r;
			// While the FIFO is full a waiting capture is overwritten by the next one: the tester cannot be stalled
			if (tg_s2_r != tg_s3_r) begin
				push_r      <= 1'b1;
				push_word_r <= cap_word_r;
			end else if (f_ready) begin
				push_r <= 1'b0;
			end
		end
	end

	// Depth covers a burst of captures while the core holds cap_ready low
	logic             f_valid;
	logic [BSR_W-1:0] f_data;
	logic             take;
	tap_fifo #(.W(BSR_W), .D(FIFO_D)) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (push_r),
		.in_ready  (f_ready),
		.in_data   (push_word_r),
		.out_valid (f_valid),
		.out_ready (take),
		.out_data  (f_data)
	);

	// Output stage register so outputs come from flops
	// A new word enters only when the stage is empty or being taken,
	// so cap_data never changes under a waiting cap_valid
	assign take = f_valid && (!cap_valid || cap_ready);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_valid <= 1'b0;
			cap_data  <= '0;
		end else if (take) begin
			cap_valid <= 1'b1;
			cap_data  <= f_data;
		end else if (cap_ready) begin
			cap_valid <= 1'b0;
		end
	end
endmodule : boundary_scan_tap

/* File: rtl/tap_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth are parameters, depth a power of two.
`timescale 1ns/1ns
module tap_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	// Honest full and empty from the occupancy count
	assign in_ready  = (cnt_r != D[AW:0]);
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage has no reset, only pointers and count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : tap_fifo

/* File: rtl/tap_pkg.sv */
// Package for the boundary-scan test logic: opcodes, widths and reset values.
// Assumes the including design runs the test logic on the test clock domain.
package tap_pkg;

	localparam int          IR_W           = 8;
	localparam logic [7:0]  OP_EXTEST      = 8'h00;
	localparam logic [7:0]  OP_SAMPLE      = 8'h01;
	localparam logic [7:0]  OP_CLAMP       = 8'h05;
	localparam logic [7:0]  OP_IDCODE      = 8'h0F;
	localparam logic [7:0]  OP_BYPASS      = 8'hFF;
	localparam logic [1:0]  IR_CAPTURE_VAL = 2'h1;
	localparam int          ID_W           = 32;
	localparam int          CELLS_PER_IO   = 3;
	localparam int          TMS_RESET_CNT  = 5;
	// Identification fields; values are arbitrary
	localparam logic [3:0]  ID_VERSION     = 4'h1;
	localparam logic [15:0] ID_PART        = 16'h1234;
	localparam logic [10:0] ID_MAKER       = 11'h0AA;
	localparam logic        ID_LSB         = 1'h1;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
		ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
		ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} tap_state_t;

endpackage : tap_pkg

/* File: verification/jtag_master.sv */
// Tester model: drives tck, tms and tdi and samples tdo.
// Assumes a 30 ns bit; tck stands low between frames, tdi idles high.
`timescale 1ns/1ns
module jtag_master (
	// Test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input wire logic  tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#15 tck = 1'b1;
		o = tdo;
		#15 tck = 1'b0;
	endtask : step
	task automatic reset5();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : reset5
	// One frame from idle back to idle, LSB first
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : scan
endmodule : jtag_master

/* File: verification/tap_asserts.sv */
// Checker for the test port and the capture stream.
// Assumes it is bound into boundary_scan_tap and sees its ports only.
`timescale 1ns/1ns
module tap_asserts #(
	parameter int N_IO = 4
) (
	// Clocks and resets
	input wire logic            clk,
	input wire logic            reset,
	input wire logic            tck,
	input wire logic            trst,
	// Test port
	input wire logic            tms,
	input wire logic            tdo_oe,
	input wire logic            test_mode,
	// Pins
	input wire logic [N_IO-1:0] pad_out,
	input wire logic [N_IO-1:0] pad_oe,
	// Stream
	input wire logic            cap_valid,
	input wire logic            cap_ready,
	input wire logic [3*N_IO-1:0] cap_data
);
	AST_TRST_OUT: assert property (@(posedge clk) disable iff (reset)
		trst |-> !tdo_oe && pad_oe == '0 && !test_mode) else $error("test reset left outputs on");
	AST_TMS5: assert property (@(posedge tck) disable iff (reset || trst)
		tms [*7] |-> !tdo_oe && !test_mode) else $error("tms high did not reset");
	AST_OE_TMS: assert property (@(posedge tck) disable iff (reset || trst)
		tms |=> !tdo_oe) else $error("shift kept after tms high");
	AST_OE_HOLD: assert property (@(posedge tck) disable iff (reset || trst)
		tdo_oe && !tms |=> tdo_oe) else $error("shift left with tms low");
	AST_OE_ENTRY: assert property (@(posedge tck) disable iff (reset || trst)
		$rose(tdo_oe) |-> !$past(tms)) else $error("shift entered with tms high");
	// Pins are registered one edge after the update latch, so they are seen two edges on
	AST_PAD_UPD: assert property (@(posedge tck) disable iff (reset || trst)
		$changed({pad_out, pad_oe}) |-> $past(tms, 2)) else $error("pins moved outside update");
	AST_CAP_VALID: assert property (@(posedge clk) disable iff (reset)
		cap_valid && !cap_ready |=> cap_valid) else $error("stream word dropped");
	AST_CAP_DATA: assert property (@(posedge clk) disable iff (reset)
		cap_valid && !cap_ready |=> $stable(cap_data)) else $error("stream word changed");
endmodule : tap_asserts

bind boundary_scan_tap tap_asserts #(.N_IO(N_IO)) u_chk (.clk(clk), .reset(reset),
	.tck(tck), .trst(trst), .tms(tms), .tdo_oe(tdo_oe), .test_mode(test_mode),
	.pad_out(pad_out), .pad_oe(pad_oe), .cap_valid(cap_valid), .cap_ready(cap_ready),
	.cap_data(cap_data));

/* File: verification/tb_top.sv */
// Self-checking bench for boundary_scan_tap with a tester model.
// Assumes clk at 100 ns; the tester runs its own unrelated tck.
`timescale 1ns/1ns
module tb_top
	import tap_pkg::*;
;
	localparam int N = 4;
	localparam int BW = 3 * N;
	logic clk, reset, trst, programmed, cap_ready, tck, tms, tdi, tdo, tdo_oe;
	logic cap_valid, test_mode;
	logic [N-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
	logic [BW-1:0] cap_data, word, exp_q[$];
	logic [31:0] so, pat, pre;
	logic [7:0] op;
	int n_fail, checks_done, cyc;

	boundary_scan_tap #(.N_IO(N), .FIFO_D(4)) u_dut (.clk(clk), .reset(reset),
		.tck(tck), .trst(trst), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.programmed(programmed), .core_out(core_out), .core_oe(core_oe),
		.core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.cap_valid(cap_valid), .cap_ready(cap_ready), .cap_data(cap_data),
		.test_mode(test_mode));
	jtag_master u_jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	always #50 clk = ~clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// Model of one captured word: cell 3i pad, 3i+1 core drive, 3i+2 enable
	function automatic logic [BW-1:0] pack(input logic [N-1:0] p, o, e);
		logic [BW-1:0] w;
		for (int i = 0; i < N; i++) w[3*i +: 3] = {e[i], o[i], p[i]};
		return w;
	endfunction : pack

	// Hang guard, well above the few hundred cycles used
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		{clk, reset, trst, programmed, cap_ready} = 5'h08;
		{pad_in, core_out, core_oe} = '0;
		{n_fail, checks_done, cyc} = '0;
		void'($urandom(54));
		repeat (20) @(posedge clk);
		#5 reset = 1'b0;
		u_jtag.reset5();
		u_jtag.scan(1'b1, IR_W, OP_IDCODE, so);
		check(so[1:0], IR_CAPTURE_VAL);
		u_jtag.scan(1'b0, ID_W, 32'h0, so);
		check(so, {ID_VERSION, ID_PART, ID_MAKER, ID_LSB});
		// one-bit path for bypass, clamp, unknown
		for (int k = 0; k < 3; k++) begin
			op = (k == 0) ? OP_BYPASS : (k == 1) ? OP_CLAMP : 8'h10 + 8'($urandom % 96);
			u_jtag.scan(1'b1, IR_W, op, so);
			pat = $urandom;
			u_jtag.scan(1'b0, 8, pat, so);
			check(so[7:0], {pat[6:0], 1'b0});
			check(test_mode, k == 1);
		end
		// captures fill the stream while it stalls
		u_jtag.scan(1'b1, IR_W, OP_SAMPLE, so);
		repeat (4) begin
			@(posedge clk);
			#5 {pad_in, core_out, core_oe} = 12'($urandom);
			word = pack(pad_in, core_out, core_oe);
			exp_q.push_back(word);
			pre = $urandom;
			u_jtag.scan(1'b0, BW, pre, so);
			check(so[BW-1:0], word);
		end
		// Drain in order with random back-pressure
		repeat (200) begin
			@(posedge clk);
			#5 cap_ready = 1'($urandom);
			@(negedge clk);
			if (cap_valid === 1'b1 && cap_ready === 1'b1 && exp_q.size() > 0)
				check(cap_data, exp_q.pop_front());
		end
		check(exp_q.size(), 0);
		u_jtag.scan(1'b1, IR_W, OP_EXTEST, so);
		check(test_mode, 1'b0);
		@(posedge clk);
		#5 programmed = 1'b1;
		u_jtag.scan(1'b1, IR_W, OP_EXTEST, so);
		check(test_mode, 1'b1);
		for (int i = 0; i < N; i++)
			check({pad_oe[i], pad_out[i], core_in[i]}, pre[3*i +: 3]);
		// tms reset drops the instruction; two extra high edges make a long run
		u_jtag.step(1'b1, 1'b1, so[0]);
		u_jtag.step(1'b1, 1'b1, so[0]);
		u_jtag.reset5();
		check(test_mode, 1'b0);
		u_jtag.scan(1'b1, IR_W, OP_EXTEST, so);
		#7 trst = 1'b1;
		#3 check({test_mode, pad_out, pad_oe}, 0);
		u_jtag.reset5();
		#150 trst = 1'b0;
		u_jtag.reset5();
		report_and_stop();
	end
endmodule : tb_top
